/* logic/sss_pkg.sv */
// constants for the status, self-test and sleep register block
package sss_pkg;
  // =====================================================
  // timing
  localparam int CLK_HZ     = 25_000_000;
  localparam int ST_TIME_MS = 46;
  localparam int ST_CYC     = ST_TIME_MS * (CLK_HZ / 1000);
  localparam int SLP_LSB_MS = 500;
  localparam int SLP_CYC    = SLP_LSB_MS * (CLK_HZ / 1000);
  // =====================================================
  // serial frame layout
  localparam logic [3:0] FRAME_LAST = 4'hf;
  localparam int         WR_BIT     = 15;
  // =====================================================
  // register byte addresses
  localparam logic [6:0] ADR_MSC  = 7'h1c;
  localparam logic [6:0] ADR_SLP  = 7'h24;
  localparam logic [6:0] ADR_DIAG = 7'h26;
  localparam logic [6:0] ADR_LOT1 = 7'h32;
  localparam logic [6:0] ADR_LOT2 = 7'h34;
  localparam logic [6:0] ADR_LOT3 = 7'h36;
  localparam logic [6:0] ADR_PROD = 7'h38;
  localparam logic [6:0] ADR_SER  = 7'h3a;
  // =====================================================
  // reset values and fields
  localparam logic [15:0] MSC_RST    = 16'h0006;
  localparam logic [15:0] DIAG_RST   = 16'h0000;
  localparam logic [7:0]  SLP_RST    = 8'h00;
  localparam logic [7:0]  SLP_HOLD   = 8'hff;
  localparam logic [15:0] SER_MASK   = 16'h3fff;
  localparam logic [15:0] DIAG_LIVE  = 16'h0301;
  localparam int          MSC_ST     = 10;
  localparam int          D_LOW      = 0;
  localparam int          D_FLASH    = 2;
  localparam int          D_SPI      = 3;
  localparam int          D_OVR      = 4;
  localparam int          D_ST       = 5;
  localparam int          D_CSUM     = 6;
  localparam int          D_AL1      = 8;
  localparam int          D_AL2      = 9;
  // =====================================================
  // power modes
  typedef enum logic [1:0] {
    PWR_AWAKE = 2'b00,
    PWR_TIMED = 2'b01,
    PWR_HOLD  = 2'b11
  } sss_pwr_t;
endpackage

/* logic/sss_status_sleep.sv */
// serial register block: self-test, sleep, diagnostics, identity
`timescale 1ns/1ns
`default_nettype none
module sss_status_sleep #(
  parameter logic [23:0] ST_CYC   = 24'(sss_pkg::ST_CYC),
  parameter logic [23:0] HALF_CYC = 24'(sss_pkg::SLP_CYC),
  parameter logic [15:0] PROD_CODE = 16'h5a01, // arbitrary value
  parameter logic [15:0] LOT_CODE1 = 16'h0001, // arbitrary value
  parameter logic [15:0] LOT_CODE2 = 16'h0002, // arbitrary value
  parameter logic [15:0] LOT_CODE3 = 16'h0003, // arbitrary value
  parameter logic [15:0] SER_NUM   = 16'h0001  // arbitrary value
) (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic csN,
  input  wire logic sclk,
  input  wire logic din,
  input  wire logic rstPinN,
  input  wire logic sampleTick,
  input  wire logic supplyLow,
  input  wire logic flashFail,
  input  wire logic overRange,
  input  wire logic csumFail,
  input  wire logic alarm1,
  input  wire logic alarm2,
  input  wire logic stFail,
  output logic      dout,
  output logic      asleep,
  output logic      stDrive
);
  // =====================================================
  // reset release and pin synchronisers
  logic [1:0]  rstSyncFf;
  logic        rstN;
  logic [3:0]  pinS1Ff;
  logic [3:0]  pinS2Ff;
  logic [3:0]  pinS3Ff;

  // reset leaves through two flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rstSyncFf <= 2'b00;
    end else begin
      rstSyncFf <= {rstSyncFf[0], 1'b1};
    end
  end
  assign rstN = rstSyncFf[1];

  // pins: [0] csN, [1] sclk, [2] din, [3] rstPinN
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      pinS1Ff <= 4'hb;
      pinS2Ff <= 4'hb;
      pinS3Ff <= 4'hb;
    end else begin
      pinS1Ff <= {rstPinN, din, sclk, csN};
      pinS2Ff <= pinS1Ff;
      pinS3Ff <= pinS2Ff;
    end
  end

  // =====================================================
  // edges and frame decode
  sss_pkg::sss_pwr_t pwrFf;
  logic        ignoreFf;
  logic        spiOn;
  logic        csFall;
  logic        csRise;
  logic        sclkRise;
  logic        sclkFall;
  logic        rstPinLow;
  logic        tick;
  logic [3:0]  bitCntFf;
  logic [15:0] rxFf;
  logic [15:0] frame;
  logic        frameDone;
  logic        isWr;
  logic [6:0]  adr;
  logic [7:0]  dat;
  logic        wrMscLo;
  logic        wrMscHi;
  logic        wrSlp;
  logic        rdDiag;
  logic        spiErr;

  assign csFall    = pinS3Ff[0] & ~pinS2Ff[0];
  assign csRise    = ~pinS3Ff[0] & pinS2Ff[0];
  assign sclkRise  = ~pinS3Ff[1] & pinS2Ff[1] & ~pinS2Ff[0];
  assign sclkFall  = pinS3Ff[1] & ~pinS2Ff[1] & ~pinS2Ff[0];
  assign rstPinLow = ~pinS2Ff[3];
  assign spiOn     = (pwrFf == sss_pkg::PWR_AWAKE) & ~ignoreFf;
  assign tick      = sampleTick & (pwrFf == sss_pkg::PWR_AWAKE);
  assign frame     = {rxFf[14:0], pinS2Ff[2]};
  assign frameDone = sclkRise & spiOn & (bitCntFf == sss_pkg::FRAME_LAST);
  assign isWr      = frame[sss_pkg::WR_BIT];
  assign adr       = frame[14:8];
  assign dat       = frame[7:0];
  assign wrMscLo   = frameDone & isWr & (adr == sss_pkg::ADR_MSC);
  assign wrMscHi   = frameDone & isWr & (adr == (sss_pkg::ADR_MSC | 7'h01));
  assign wrSlp     = frameDone & isWr & (adr == sss_pkg::ADR_SLP);
  assign rdDiag    = frameDone & ~isWr
                     & ({adr[6:1], 1'b0} == sss_pkg::ADR_DIAG);
  assign spiErr    = csRise & spiOn & (bitCntFf != 4'h0);

  // clock count, restarted by each select, and input shifter
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      bitCntFf <= 4'h0;
      rxFf     <= 16'h0000;
    end else if (csFall) begin
      bitCntFf <= 4'h0;
    end else if (sclkRise && spiOn) begin
      bitCntFf <= bitCntFf + 4'h1;
      rxFf     <= frame;
    end
  end

  // the frame whose select woke the device is ignored
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      ignoreFf <= 1'b0;
    end else if (csFall) begin
      ignoreFf <= (pwrFf != sss_pkg::PWR_AWAKE);
    end
  end

  // =====================================================
  // self-test
  logic [15:0] mscFf;
  logic [23:0] stCntFf;
  logic        stDone;

  assign stDone = mscFf[sss_pkg::MSC_ST] & tickAwake()
                  & (stCntFf == ST_CYC - 24'h1);

  function automatic logic tickAwake();
    return pwrFf == sss_pkg::PWR_AWAKE;
  endfunction

  // test duration count, frozen while asleep
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      stCntFf <= 24'h0;
    end else if (!mscFf[sss_pkg::MSC_ST] || stDone) begin
      stCntFf <= 24'h0;
    end else if (tickAwake()) begin
      stCntFf <= stCntFf + 24'h1;
    end
  end

  // misc_control bytes; the test bit drops at completion
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      mscFf <= sss_pkg::MSC_RST;
    end else begin
      if (stDone) begin
        mscFf[sss_pkg::MSC_ST] <= 1'b0;
      end
      if (wrMscLo) begin
        mscFf[7:0] <= dat;
      end
      if (wrMscHi) begin
        mscFf[15:8] <= dat;
      end
    end
  end
  assign stDrive = mscFf[sss_pkg::MSC_ST];

  // =====================================================
  // sleep control
  logic [7:0]  slpFf;
  logic        pendSlpFf;
  logic [7:0]  leftFf;
  logic [23:0] halfCntFf;
  logic        halfTick;

  assign halfTick = (halfCntFf == HALF_CYC - 24'h1);

  // sleep byte and a request armed until select rises
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      slpFf     <= sss_pkg::SLP_RST;
      pendSlpFf <= 1'b0;
    end else if (wrSlp) begin
      slpFf     <= dat;
      pendSlpFf <= 1'b1;
    end else if (csRise) begin
      pendSlpFf <= 1'b0;
    end
  end

  // power mode, half-second timer and remaining count
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      pwrFf     <= sss_pkg::PWR_AWAKE;
      leftFf    <= 8'h00;
      halfCntFf <= 24'h0;
    end else begin
      case (pwrFf)
        sss_pkg::PWR_AWAKE: begin
          halfCntFf <= 24'h0;
          leftFf    <= slpFf;
          if (csRise && pendSlpFf && !rstPinLow) begin
            pwrFf <= (slpFf == sss_pkg::SLP_HOLD) ? sss_pkg::PWR_HOLD
                                                  : sss_pkg::PWR_TIMED;
          end
        end
        sss_pkg::PWR_TIMED: begin
          halfCntFf <= halfTick ? 24'h0 : halfCntFf + 24'h1;
          if (halfTick) begin
            leftFf <= leftFf - 8'h01;
          end
          if (csFall || rstPinLow || leftFf == 8'h00) begin
            pwrFf <= sss_pkg::PWR_AWAKE;
          end
        end
        sss_pkg::PWR_HOLD: begin
          if (csFall || rstPinLow) begin
            pwrFf <= sss_pkg::PWR_AWAKE;
          end
        end
        default: begin
          pwrFf <= sss_pkg::PWR_AWAKE;
        end
      endcase
    end
  end

  // sleep indication output
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      asleep <= 1'b0;
    end else begin
      asleep <= (pwrFf != sss_pkg::PWR_AWAKE);
    end
  end

  // =====================================================
  // diagnostic flags
  logic [15:0] diagFf;
  logic [15:0] evt;

  // new errors; live bits follow their conditions per sample
  always_comb begin
    evt                  = 16'h0000;
    evt[sss_pkg::D_LOW]  = tick & supplyLow;
    evt[sss_pkg::D_FLASH] = tick & flashFail;
    evt[sss_pkg::D_SPI]  = spiErr;
    evt[sss_pkg::D_OVR]  = tick & overRange;
    evt[sss_pkg::D_ST]   = stDone & stFail;
    evt[sss_pkg::D_CSUM] = tick & csumFail;
    evt[sss_pkg::D_AL1]  = tick & alarm1;
    evt[sss_pkg::D_AL2]  = tick & alarm2;
  end

  // read clears all, a same-cycle error still sets
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      diagFf <= sss_pkg::DIAG_RST;
    end else begin
      diagFf <= (diagFf & ~({16{rdDiag}} | {16{tick}} & sss_pkg::DIAG_LIVE))
                | evt;
    end
  end

  // =====================================================
  // read data and output shifter
  logic [15:0] rdData;
  logic [15:0] txFf;
  logic        doutFf;

  // read value of the addressed register pair
  always_comb begin
    case ({adr[6:1], 1'b0})
      sss_pkg::ADR_MSC:  rdData = mscFf;
      sss_pkg::ADR_SLP:  rdData = {8'h00, slpFf};
      sss_pkg::ADR_DIAG: rdData = diagFf;
      sss_pkg::ADR_LOT1: rdData = LOT_CODE1;
      sss_pkg::ADR_LOT2: rdData = LOT_CODE2;
      sss_pkg::ADR_LOT3: rdData = LOT_CODE3;
      sss_pkg::ADR_PROD: rdData = PROD_CODE;
      sss_pkg::ADR_SER:  rdData = SER_NUM & sss_pkg::SER_MASK;
      default:           rdData = 16'h0000;
    endcase
  end

  // answer loads at frame end, shifts out on falling clocks
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      txFf   <= 16'h0000;
      doutFf <= 1'b0;
    end else if (frameDone) begin
      txFf <= isWr ? 16'h0000 : rdData;
    end else if (sclkFall && spiOn) begin
      doutFf <= txFf[15];
      txFf   <= {txFf[14:0], 1'b0};
    end
  end
  assign dout = doutFf;

  // =====================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstN);

  AST_ST_START: assert property (
    wrMscHi && dat[2] |=> stDrive && mscFf[sss_pkg::MSC_ST])
    else $error("self-test did not start");
  AST_ST_END: assert property (
    stDone && !wrMscHi |=> !stDrive && stCntFf == 24'h0)
    else $error("self-test bit not cleared");
  AST_ST_FAIL: assert property (
    stDone && stFail |=> diagFf[sss_pkg::D_ST])
    else $error("self-test failure not flagged");
  AST_HOLD_SLEEP: assert property (
    pwrFf == sss_pkg::PWR_AWAKE && csRise && pendSlpFf && !rstPinLow
    && slpFf == sss_pkg::SLP_HOLD |=> ##1 asleep && pwrFf == sss_pkg::PWR_HOLD)
    else $error("hold sleep not entered");
  AST_CS_WAKE: assert property (
    pwrFf != sss_pkg::PWR_AWAKE && csFall |=> pwrFf == sss_pkg::PWR_AWAKE
    ##1 !asleep)
    else $error("select fall did not wake");
  AST_TIMED_WAKE: assert property (
    pwrFf == sss_pkg::PWR_TIMED && leftFf == 8'h00
    |=> pwrFf == sss_pkg::PWR_AWAKE)
    else $error("timed sleep overran");
  AST_READ_CLEAR: assert property (
    rdDiag && evt == 16'h0000 |=> diagFf == 16'h0000
    && txFf == $past(diagFf))
    else $error("flag read did not clear");
  AST_SPI_ERR: assert property (
    spiErr |=> diagFf[sss_pkg::D_SPI])
    else $error("bad clock count not flagged");
  AST_LOW_CLEAR: assert property (
    tick && !supplyLow |=> !diagFf[sss_pkg::D_LOW])
    else $error("low-supply flag stuck");
  AST_SLEEP_DEAF: assert property (
    pwrFf != sss_pkg::PWR_AWAKE |-> !frameDone && !tick)
    else $error("traffic accepted while asleep");
endmodule
`default_nettype wire

/* sim/sss_host.sv */
// serial host model that frames traffic to the status and sleep block
`timescale 1ns/1ns
`default_nettype none
module sss_host (
  input  wire logic mclk,
  input  wire logic dout,
  output var logic  csN,
  output var logic  sclk,
  output var logic  din
);
  // =====================================================
  // idle levels: deselected, clock high, data line low
  initial begin
    csN  = 1'b1;
    sclk = 1'b1;
    din  = 1'b0;
  end

  // one chip-select sequence of n clocks, msb first, mode 3;
  // reply bits are taken from clock 17 onward
  task automatic xfer(input logic [31:0] w, input int n,
                      output logic [15:0] r);
    r = 16'h0000;
    @(negedge mclk) csN = 1'b0;
    repeat (6) @(negedge mclk);
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      din  = w[31-i];
      repeat (6) @(negedge mclk); // half period well above 3 clocks
      if (i >= 16) r = {r[14:0], dout};
      sclk = 1'b1;
      repeat (6) @(negedge mclk);
    end
    csN = 1'b1;
    din = ~din; // released line shows no stale value
    repeat (6) @(negedge mclk);
  endtask
endmodule
`default_nettype wire

/* sim/tb.sv */
// self-checking bench for the status, self-test and sleep block
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        mclk, reset_n, rstPinN, sampleTick, stFail;
  logic        supplyLow, flashFail, overRange, csumFail, alarm1, alarm2;
  logic        csN, sclk, din, dout, asleep, stDrive;
  logic [15:0] rv;
  int          nMismatch;
  int          testsRun;

  // product and first lot code keep their defaults
  sss_status_sleep #(.ST_CYC(24'd50), .HALF_CYC(24'd20),
    .LOT_CODE2(16'h2222), .LOT_CODE3(16'h3333), // arbitrary values
    .SER_NUM(16'he70f)) sss_status_sleep_inst (
    .mclk(mclk), .reset_n(reset_n), .csN(csN), .sclk(sclk), .din(din),
    .rstPinN(rstPinN), .sampleTick(sampleTick), .supplyLow(supplyLow),
    .flashFail(flashFail), .overRange(overRange), .csumFail(csumFail),
    .alarm1(alarm1), .alarm2(alarm2), .stFail(stFail), .dout(dout),
    .asleep(asleep), .stDrive(stDrive));

  sss_host sss_host_inst (.mclk(mclk), .dout(dout), .csN(csN),
    .sclk(sclk), .din(din));

  // =====================================================
  // clock, checks and closing
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic cmpWord(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmpBit(input logic got, input logic exp);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic endOfTest();
    $display("checks %0d mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // =====================================================
  // bus helpers and stimulus helpers
  task automatic rd(input logic [6:0] a, output logic [15:0] r);
    sss_host_inst.xfer({1'b0, a, 8'h00, 16'h0000}, 32, r);
  endtask

  task automatic wr(input logic [15:0] w);
    logic [15:0] r;
    sss_host_inst.xfer({w, 16'h0000}, 16, r);
  endtask

  task automatic tick();
    @(negedge mclk) sampleTick = 1'b1;
    @(negedge mclk) sampleTick = 1'b0;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // =====================================================
  // scenarios
  task automatic t_ident();
    rd(sss_pkg::ADR_DIAG, rv); cmpWord(rv, 16'h0000);
    rd(sss_pkg::ADR_PROD, rv); cmpWord(rv, 16'h5a01);
    rd(sss_pkg::ADR_LOT1, rv); cmpWord(rv, 16'h0001);
    rd(sss_pkg::ADR_LOT2, rv); cmpWord(rv, 16'h2222);
    rd(sss_pkg::ADR_LOT3, rv); cmpWord(rv, 16'h3333);
    rd(sss_pkg::ADR_SER, rv); cmpWord(rv, 16'h270f);
  endtask

  task automatic t_selftest();
    stFail = 1'b1;
    wr(16'h9d04);
    cmpBit(stDrive, 1'b1);
    wait_n(60);
    cmpBit(stDrive, 1'b0);
    stFail = 1'b0;
    rd(sss_pkg::ADR_MSC, rv); cmpWord(rv, 16'h0006);
    rd(sss_pkg::ADR_DIAG, rv); cmpWord(rv, 16'h0020);
  endtask

  task automatic t_diag();
    {supplyLow, flashFail, overRange, csumFail, alarm1, alarm2} = 6'h3f;
    tick();
    rd(sss_pkg::ADR_DIAG, rv); cmpWord(rv, 16'h0355);
    rd(sss_pkg::ADR_DIAG, rv); cmpWord(rv, 16'h0000);
    {flashFail, overRange, csumFail, alarm1, alarm2} = 5'h00;
    tick();
    rd(sss_pkg::ADR_DIAG, rv); cmpWord(rv, 16'h0001);
    tick();
    supplyLow = 1'b0;
    tick();
    rd(sss_pkg::ADR_DIAG, rv); cmpWord(rv, 16'h0000);
  endtask

  task automatic t_spifail();
    sss_host_inst.xfer({16'h2600, 16'h0000}, 12, rv);
    rd(sss_pkg::ADR_DIAG, rv); cmpWord(rv, 16'h0008);
  endtask

  task automatic t_timed();
    wr(16'ha402);
    wait_n(8); cmpBit(asleep, 1'b1);
    wait_n(20); cmpBit(asleep, 1'b1);
    wait_n(30); cmpBit(asleep, 1'b0);
  endtask

  task automatic t_hold();
    wr(16'ha5ff);
    wait_n(8); cmpBit(asleep, 1'b0);
    wr(16'ha4ff);
    alarm1 = 1'b1;
    tick();
    alarm1 = 1'b0;
    wait_n(100); cmpBit(asleep, 1'b1);
    rd(sss_pkg::ADR_DIAG, rv);
    wait_n(4); cmpBit(asleep, 1'b0);
    rd(sss_pkg::ADR_DIAG, rv); cmpWord(rv, 16'h0000);
    wr(16'ha4ff);
    wait_n(8); cmpBit(asleep, 1'b1);
    rstPinN = 1'b0;
    wait_n(4);
    rstPinN = 1'b1;
    wait_n(8); cmpBit(asleep, 1'b0);
  endtask

  // =====================================================
  // main sequence
  initial begin
    nMismatch = 0;
    testsRun = 0;
    reset_n = 1'b0;
    rstPinN = 1'b1;
    sampleTick = 1'b0;
    stFail = 1'b0;
    {supplyLow, flashFail, overRange, csumFail, alarm1, alarm2} = 6'h00;
    wait_n(20);
    reset_n = 1'b1;
    wait_n(6);
    cmpBit(asleep, 1'b0);
    t_ident();
    t_selftest();
    t_diag();
    t_spifail();
    t_timed();
    t_hold();
    endOfTest();
  end

  // watchdog well beyond the expected run of about 7500 clocks
  initial begin
    #3_000_000;
    nMismatch++;
    endOfTest();
  end
endmodule
`default_nettype wire
